// ===== logic/urp_port.sv
// Root-hub port status, control and resume logic for one downstream port
`timescale 1ns/1ps
`default_nettype none
module urp_port (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic [urp_pkg::PSC_WIDTH-1:0] reg_wdata,
    output logic [urp_pkg::PSC_WIDTH-1:0] reg_rdata,
    input wire logic global_suspend,
    input wire logic global_resume,
    input wire logic xact_busy,
    input wire logic eof2_strobe,
    input wire logic eof2_fault,
    input wire logic dp_in,
    input wire logic dm_in,
    output logic dp_out,
    output logic dm_out,
    output logic line_oe,
    output logic port_enabled,
    output logic host_resume_set
);
    import urp_pkg::*;

    // Idle J: D+ high at full speed, D- high at low speed
    function automatic logic line_is_j(input logic [1:0] ln, input logic ls);
        line_is_j = ls ? (ln == 2'b01) : (ln == 2'b10);
    endfunction : line_is_j

    function automatic logic line_is_k(input logic [1:0] ln, input logic ls);
        line_is_k = ls ? (ln == 2'b10) : (ln == 2'b01);
    endfunction : line_is_k

    logic [1:0] line_s;
    logic [1:0] line_prev_reg;
    logic conn_reg, conn_next, conn_chg_reg, conn_chg_next;
    logic en_reg, en_next, en_chg_reg, en_chg_next, dis_pend_reg, dis_pend_next;
    logic susp_reg, susp_next, prst_reg, prst_next, ls_reg, ls_next;
    logic res_reg, res_next, res_clr_reg, res_clr_next;
    logic [1:0] lstat_reg, lstat_next;
    logic dp_reg, dp_next, dm_reg, dm_next, oe_reg, oe_next;
    logic hres_reg, hres_next;
    logic [PSC_WIDTH-1:0] rdata_reg, rdata_next;
    logic eop_start, eop_busy, eop_se0, eop_done;
    logic drive_k, conn_evt, jk_evt, hw_disable;
    urp_state_e state;

    urp_sync u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .pin_in({dp_in, dm_in}),
        .pin_sync(line_s)
    );

    urp_eop u_eop (
        .mclk(mclk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .start(eop_start),
        .busy(eop_busy),
        .se0(eop_se0),
        .done(eop_done)
    );

    // Port state from enable and suspend
    assign state = !en_reg ? URP_ST_DISABLED :
                   (susp_reg ? URP_ST_SUSPENDED : URP_ST_ENABLED);

    // Line events, masked while we drive so our own signalling is not seen
    assign drive_k = (res_reg && !res_clr_reg && state == URP_ST_SUSPENDED)
                     || (global_resume && en_reg);
    assign conn_evt = !oe_reg && ((line_s != 2'b00) != conn_reg);
    assign jk_evt = !oe_reg && state == URP_ST_SUSPENDED
                    && line_is_j(line_prev_reg, ls_reg) && line_is_k(line_s, ls_reg);
    // Disconnect at once; fault only at the checkpoint of an enabled port
    assign hw_disable = (conn_evt && conn_reg) || (eof2_strobe && eof2_fault && en_reg);

    // Resume bit and end-of-packet sequencing
    always_comb begin
        res_next = res_reg;
        res_clr_next = res_clr_reg;
        eop_start = 1'b0;
        if (reg_wr && reg_wdata[PSC_RESUME_BIT]) begin
            res_next = 1'b1;
            res_clr_next = 1'b0;
        end else if (reg_wr && res_reg && !res_clr_reg) begin
            eop_start = 1'b1;
            res_clr_next = 1'b1;
        end
        if (res_clr_reg && eop_done) begin
            res_next = 1'b0;
            res_clr_next = 1'b0;
        end
        if (jk_evt) begin
            res_next = 1'b1;
            res_clr_next = 1'b0;
        end
    end

    // Enable, suspend, port reset and disable deferral
    always_comb begin
        en_next = en_reg;
        dis_pend_next = dis_pend_reg;
        susp_next = susp_reg;
        prst_next = prst_reg;
        if (reg_wr) begin
            susp_next = reg_wdata[PSC_SUSPEND_BIT];
            prst_next = reg_wdata[PSC_PORT_RESET_BIT];
            if (reg_wdata[PSC_ENABLE_BIT]) begin
                en_next = 1'b1;
                dis_pend_next = 1'b0;
            end else if (en_reg) begin
                dis_pend_next = 1'b1;
            end
        end
        if (dis_pend_reg && !xact_busy) begin
            en_next = 1'b0;
            dis_pend_next = 1'b0;
        end
        if (hw_disable) begin
            en_next = 1'b0;
            dis_pend_next = 1'b0;
        end
        if (!en_next) begin
            susp_next = 1'b0;
        end
    end

    // Connect, change flags, speed and line status; set beats clear
    always_comb begin
        conn_next = conn_reg;
        ls_next = ls_reg;
        lstat_next = lstat_reg;
        conn_chg_next = conn_chg_reg;
        en_chg_next = en_chg_reg;
        if (reg_wr && reg_wdata[PSC_CONN_CHG_BIT]) begin
            conn_chg_next = 1'b0;
        end
        if (reg_wr && reg_wdata[PSC_EN_CHG_BIT]) begin
            en_chg_next = 1'b0;
        end
        if (conn_evt) begin
            conn_next = !conn_reg;
            conn_chg_next = 1'b1;
            if (!conn_reg) begin
                ls_next = line_s[0];
            end
        end
        if (hw_disable) begin
            en_chg_next = 1'b1;
        end
        if (eof2_strobe) begin
            lstat_next = {line_s[0], line_s[1]};
        end
    end

    // Pin drive: EOP first, then K; registered outputs
    always_comb begin
        oe_next = eop_busy || eop_start || drive_k;
        dp_next = 1'b0;
        dm_next = 1'b0;
        if (eop_busy && !eop_se0) begin
            dp_next = 1'b0;
            dm_next = 1'b1;
        end else if (!eop_busy && !eop_start && drive_k) begin
            dp_next = ls_reg;
            dm_next = !ls_reg;
        end
        // Wake the host controller only while it is globally suspended
        hres_next = global_suspend && ((res_next && !res_reg)
                    || (conn_chg_next && (!conn_chg_reg || conn_evt))
                    || (en_chg_next && !en_chg_reg)
                    || (!oe_reg && en_reg && line_is_k(line_s, ls_reg)));
        rdata_next = '0;
        rdata_next[PSC_CONN_BIT] = conn_reg;
        rdata_next[PSC_CONN_CHG_BIT] = conn_chg_reg;
        rdata_next[PSC_ENABLE_BIT] = en_reg;
        rdata_next[PSC_EN_CHG_BIT] = en_chg_reg;
        rdata_next[PSC_LINE_HI_BIT:PSC_LINE_LO_BIT] = lstat_reg;
        rdata_next[PSC_RESUME_BIT] = res_reg;
        rdata_next[PSC_RSVD_ONE_BIT] = 1'b1;
        rdata_next[PSC_LOW_SPEED_BIT] = ls_reg;
        rdata_next[PSC_PORT_RESET_BIT] = prst_reg;
        rdata_next[PSC_SUSPEND_BIT] = susp_reg;
    end

    // State registers; all values after reset are constants
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            conn_reg <= 1'b0;
            conn_chg_reg <= 1'b0;
            en_reg <= 1'b0;
            en_chg_reg <= 1'b0;
            dis_pend_reg <= 1'b0;
            susp_reg <= 1'b0;
            prst_reg <= 1'b0;
            ls_reg <= 1'b0;
            res_reg <= 1'b0;
            res_clr_reg <= 1'b0;
            lstat_reg <= LINE_RESET_VALUE;
            line_prev_reg <= 2'h0;
            dp_reg <= 1'b0;
            dm_reg <= 1'b0;
            oe_reg <= 1'b0;
            hres_reg <= 1'b0;
            rdata_reg <= PSC_RESET_VALUE;
        end else if (clk_en) begin
            conn_reg <= conn_next;
            conn_chg_reg <= conn_chg_next;
            en_reg <= en_next;
            en_chg_reg <= en_chg_next;
            dis_pend_reg <= dis_pend_next;
            susp_reg <= susp_next;
            prst_reg <= prst_next;
            ls_reg <= ls_next;
            res_reg <= res_next;
            res_clr_reg <= res_clr_next;
            lstat_reg <= lstat_next;
            line_prev_reg <= line_s;
            dp_reg <= dp_next;
            dm_reg <= dm_next;
            oe_reg <= oe_next;
            hres_reg <= hres_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign dp_out = dp_reg;
    assign dm_out = dm_reg;
    assign line_oe = oe_reg;
    assign port_enabled = en_reg;
    assign host_resume_set = hres_reg;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_clear_resume;
        clk_en && reg_wr && !reg_wdata[PSC_RESUME_BIT] && res_reg && !res_clr_reg;
    endsequence
    sequence s_eop_runs;
        clk_en [*1] ##1 (res_reg && eop_busy);
    endsequence

    // Read image holds reset value until its first enabled load
    property p_rsvd_one;
        $past(reset_n) && $past(clk_en) |-> rdata_reg[PSC_RSVD_ONE_BIT];
    endproperty
    a_rsvd_one: assert property (p_rsvd_one) else $error("reserved bit not 1");

    property p_resume_held;
        s_clear_resume |-> s_eop_runs;
    endproperty
    a_resume_held: assert property (p_resume_held) else $error("resume dropped early");

    property p_no_sw_enable_by_hw;
        clk_en && !en_reg && !reg_wr |=> !en_reg;
    endproperty
    a_no_sw_enable_by_hw: assert property (p_no_sw_enable_by_hw) else $error("enable set by hw");

    property p_defer_disable;
        clk_en && dis_pend_reg && xact_busy && !hw_disable |=> en_reg;
    endproperty
    a_defer_disable: assert property (p_defer_disable) else $error("disable not deferred");

    property p_conn_chg_set;
        clk_en && conn_evt |=> conn_chg_reg ##1 rdata_reg[PSC_CONN_CHG_BIT] || !clk_en;
    endproperty
    a_conn_chg_set: assert property (p_conn_chg_set) else $error("connect change lost");

    property p_en_chg_cause;
        clk_en && !en_chg_reg && !hw_disable |=> !en_chg_reg;
    endproperty
    a_en_chg_cause: assert property (p_en_chg_cause) else $error("spurious enable change");

    property p_disconnect;
        clk_en && conn_evt && conn_reg |=> !conn_reg && !en_reg && en_chg_reg && conn_chg_reg;
    endproperty
    a_disconnect: assert property (p_disconnect) else $error("disconnect handling");

    property p_global_k;
        clk_en && global_resume && en_reg && !eop_busy && !eop_start |=> oe_reg && dm_reg != dp_reg;
    endproperty
    a_global_k: assert property (p_global_k) else $error("no global K");

    // Resume bit rising without a software write needs a suspended port
    property p_resume_only_suspended;
        clk_en && !res_reg && !(reg_wr && reg_wdata[PSC_RESUME_BIT])
            |=> !res_reg || $past(en_reg && susp_reg);
    endproperty
    a_resume_only_suspended: assert property (p_resume_only_suspended) else $error("bad resume");

    property p_wake_needs_gsusp;
        host_resume_set |-> $past(global_suspend);
    endproperty
    a_wake_needs_gsusp: assert property (p_wake_needs_gsusp) else $error("wake without suspend");
endmodule : urp_port
`default_nettype wire

// ===== logic/urp_pkg.sv
// Constants shared by the root-hub port status and resume logic
package urp_pkg;
    // Port status and control register field positions
    localparam int PSC_CONN_BIT = 0;
    localparam int PSC_CONN_CHG_BIT = 1;
    localparam int PSC_ENABLE_BIT = 2;
    localparam int PSC_EN_CHG_BIT = 3;
    localparam int PSC_LINE_LO_BIT = 4;
    localparam int PSC_LINE_HI_BIT = 5;
    localparam int PSC_RESUME_BIT = 6;
    localparam int PSC_RSVD_ONE_BIT = 7;
    localparam int PSC_LOW_SPEED_BIT = 8;
    localparam int PSC_PORT_RESET_BIT = 9;
    localparam int PSC_SUSPEND_BIT = 12;
    localparam int PSC_WIDTH = 16;
    // Register offsets from the I/O base, one word per port
    localparam logic [7:0] PSC_PORT1_OFFSET = 8'h10;
    localparam logic [7:0] PSC_PORT2_OFFSET = 8'h12;
    // Values after reset
    localparam logic [15:0] PSC_RESET_VALUE = 16'h0000;
    localparam logic [1:0] LINE_RESET_VALUE = 2'h0;
    // Host command and status bits the port logic is tied to
    localparam int HCMD_GSUSPEND_BIT = 3;
    localparam int HCMD_GRESUME_BIT = 4;
    localparam int HSTS_RESUME_BIT = 2;
    // Timing: one low-speed bit at 1.5 Mb/s against a 40 MHz clock
    localparam int CLK_PERIOD_PS = 25000;
    localparam int LS_BIT_PS = 666667;
    localparam int LS_BIT_CYCLES = (LS_BIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int EOP_SE0_BITS = 2;
    localparam int EOP_J_BITS = 1;
    localparam int EOP_SE0_CYCLES = EOP_SE0_BITS * LS_BIT_CYCLES;
    localparam int EOP_TOTAL_CYCLES = (EOP_SE0_BITS + EOP_J_BITS) * LS_BIT_CYCLES;
    localparam int EOP_CNT_W = 8;
    // Port state decoded from enable and suspend
    typedef enum logic [1:0] {
        URP_ST_DISABLED = 2'b00,
        URP_ST_ENABLED = 2'b01,
        URP_ST_SUSPENDED = 2'b11
    } urp_state_e;
endpackage : urp_pkg

// ===== logic/urp_sync.sv
// Two flip-flop synchroniser for the D+ and D- pins
`timescale 1ns/1ps
`default_nettype none
module urp_sync (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_sync
);
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 2'h0;
            sync_reg <= 2'h0;
        end else if (clk_en) begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign pin_sync = sync_reg;
endmodule : urp_sync
`default_nettype wire

// ===== logic/urp_eop.sv
// Low-speed end-of-packet generator: two bit times of SE0, then one of J
`timescale 1ns/1ps
`default_nettype none
module urp_eop (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic start,
    output logic busy,
    output logic se0,
    output logic done
);
    import urp_pkg::*;
    logic [EOP_CNT_W-1:0] cnt_reg;
    logic [EOP_CNT_W-1:0] cnt_next;
    logic done_next;
    logic done_reg;

    // Count down through the whole end-of-packet; start is ignored while busy
    always_comb begin
        cnt_next = cnt_reg;
        done_next = 1'b0;
        if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
            done_next = (cnt_reg == EOP_CNT_W'(1));
        end else if (start) begin
            // The start cycle already shows SE0 at the pins, so load one less
            cnt_next = EOP_CNT_W'(EOP_TOTAL_CYCLES - 1);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else if (clk_en) begin
            cnt_reg <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign busy = (cnt_reg != '0);
    // SE0 for the first part, J for the last bit time
    assign se0 = (cnt_reg > EOP_CNT_W'(EOP_TOTAL_CYCLES - EOP_SE0_CYCLES));
    assign done = done_reg;
endmodule : urp_eop
`default_nettype wire

// ===== test/urp_dev_model.sv
// Behavioural USB device on one downstream port, with line resolution
`timescale 1ns/1ps
`default_nettype none
module urp_dev_model (
    input wire logic attach,
    input wire logic low_spd,
    input wire logic send_k,
    input wire logic line_oe,
    input wire logic dp_out,
    input wire logic dm_out,
    output logic dp_in,
    output logic dm_in
);
    logic [1:0] dev_j;
    // Idle J depends on speed; K is the inverse
    always_comb begin
        dev_j = low_spd ? 2'b01 : 2'b10;
        if (line_oe) begin
            // Host drive wins while it owns the line
            {dp_in, dm_in} = {dp_out, dm_out};
        end else if (!attach) begin
            // Host pull-downs leave SE0 on an empty port
            {dp_in, dm_in} = 2'b00;
        end else begin
            {dp_in, dm_in} = send_k ? ~dev_j : dev_j;
        end
    end
endmodule : urp_dev_model
`default_nettype wire

// ===== test/urp_port_tb.sv
// Self-checking bench for the root-hub port status and resume logic
`timescale 1ns/1ps
`default_nettype none
module urp_port_tb;
    import urp_pkg::*;
    logic mclk, reset_n, reg_wr, global_suspend, global_resume, xact_busy;
    logic eof2_strobe, eof2_fault, dp_in, dm_in, dp_out, dm_out, line_oe;
    logic port_enabled, host_resume_set, attach, low_spd, send_k, clk_en;
    logic [15:0] reg_wdata, reg_rdata;
    logic [1:0] jp;
    int num_errors = 0;
    int cmp_count = 0;
    int pulses = 0;

    urp_port urp_port_inst (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .global_suspend(global_suspend), .global_resume(global_resume),
        .xact_busy(xact_busy), .eof2_strobe(eof2_strobe), .eof2_fault(eof2_fault),
        .dp_in(dp_in), .dm_in(dm_in), .dp_out(dp_out), .dm_out(dm_out),
        .line_oe(line_oe), .port_enabled(port_enabled),
        .host_resume_set(host_resume_set));
    urp_dev_model urp_dev_model_inst (.attach(attach), .low_spd(low_spd),
        .send_k(send_k), .line_oe(line_oe), .dp_out(dp_out), .dm_out(dm_out),
        .dp_in(dp_in), .dm_in(dm_in));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Counts clock cycles in which a wake request toward the host status register is high
    always @(posedge mclk) begin
        if (host_resume_set === 1'b1) pulses++;
    end

    // Expected idle J pair {dp, dm} for the attached speed
    function automatic logic [1:0] j_pair(input logic ls);
        return ls ? 2'b01 : 2'b10;
    endfunction : j_pair

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic wr(input logic [15:0] d);
        reg_wr = 1'b1;
        reg_wdata = d;
        step(1);
        reg_wr = 1'b0;
    endtask : wr
    task automatic chk(input logic [15:0] mask, input logic [15:0] exp);
        cmp_count++;
        if ((reg_rdata & mask) !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t rdata=%h mask=%h exp=%h", $time, reg_rdata, mask, exp);
        end
    endtask : chk
    task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t pins/flags got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmpi(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            num_errors++;
            $display("MISMATCH t=%0t count got=%0d exp=%0d", $time, got, exp);
        end
    endtask : cmpi
    // Follows an end-of-packet to its close, timing SE0 and J phases
    task automatic run_eop;
        int se0;
        int jn;
        int lost;
        bit seen;
        se0 = 0;
        jn = 0;
        lost = 0;
        seen = 0;
        // Look before stepping: the clearing write's edge already drives SE0
        for (int i = 0; i < 400; i++) begin
            if (line_oe === 1'b1) begin
                seen = 1;
                if (dp_out === 1'b0 && dm_out === 1'b0) se0++;
                else if (dp_out === 1'b0 && dm_out === 1'b1) jn++;
                if (reg_rdata[6] !== 1'b1) lost++;
            end else if (seen) begin
                break;
            end
            step(1);
        end
        cmpi(se0, EOP_SE0_CYCLES);
        cmpi(jn, EOP_TOTAL_CYCLES - EOP_SE0_CYCLES);
        cmpi(lost, 0);
        step(3);
        chk(16'h1040, 16'h0000);
    endtask : run_eop

    task automatic summarize;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // Watchdog well beyond the expected run of about 400 cycles
    initial begin
        #(25 * 6000);
        num_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        summarize();
    end

    initial begin
        {reset_n, reg_wr, global_suspend, global_resume, xact_busy} = 5'h00;
        {eof2_strobe, eof2_fault, attach, send_k} = 4'h0;
        reg_wdata = 16'h0000;
        clk_en = 1'b1;
        void'($urandom(32'hA565B546));
        low_spd = 1'($urandom % 2);
        jp = j_pair(low_spd);
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        step(2);
        chk(16'hFFFF, 16'h0080);
        wr(16'h0180);
        step(2);
        chk(16'hFFFF, 16'h0080);
        // Attach a device of random speed; both connect bits must rise
        attach = 1'b1;
        step(8);
        chk(16'h0103, {7'h00, low_spd, 8'h03});
        wr(16'h0002);
        step(2);
        chk(16'h0103, {7'h00, low_spd, 8'h01});
        eof2_strobe = 1'b1;
        step(1);
        eof2_strobe = 1'b0;
        step(3);
        cmp({2'b00, reg_rdata[5:4]}, {2'b00, jp[0], jp[1]});
        // Enable, then a software disable held back by a busy bus
        wr(16'h0004);
        step(2);
        cmp({2'b00, reg_rdata[2], port_enabled}, 4'h3);
        // Frozen clock enable: a disabling write must not be taken
        clk_en = 1'b0;
        wr(16'h0000);
        step(3);
        clk_en = 1'b1;
        step(3);
        cmp({2'b00, reg_rdata[2], port_enabled}, 4'h3);
        xact_busy = 1'b1;
        wr(16'h0000);
        step($urandom_range(10, 3));
        chk(16'h000C, 16'h0004);
        xact_busy = 1'b0;
        step(4);
        chk(16'h000C, 16'h0000);
        // Fault at the end-of-frame checkpoint disables the port
        wr(16'h0004);
        eof2_strobe = 1'b1;
        eof2_fault = 1'b1;
        step(1);
        {eof2_strobe, eof2_fault} = 2'b00;
        step(4);
        chk(16'h000C, 16'h0008);
        wr(16'h0008);
        step(1);
        wr(16'h0004);
        step(3);
        chk(16'h000C, 16'h0004);
        // Software resume on a suspended port, then a joint clear
        wr(16'h1004);
        step(3);
        chk(16'h1044, 16'h1004);
        wr(16'h1044);
        step($urandom_range(12, 4));
        cmp({1'b0, line_oe, dp_out, dm_out}, {2'b01, ~j_pair(low_spd)});
        wr(16'h0004);
        run_eop();
        // Remote wake from the device under global suspend
        wr(16'h1004);
        step(3);
        global_suspend = 1'b1;
        pulses = 0;
        send_k = 1'b1;
        step(8);
        chk(16'h1044, 16'h1044);
        cmpi(int'(pulses > 0), 1);
        send_k = 1'b0;
        global_suspend = 1'b0;
        wr(16'h0004);
        run_eop();
        // Device K on an enabled, not suspended port
        step(6);
        global_suspend = 1'b1;
        pulses = 0;
        send_k = 1'b1;
        step(8);
        chk(16'h0040, 16'h0000);
        cmpi(int'(pulses > 0), 1);
        send_k = 1'b0;
        global_suspend = 1'b0;
        step(8);
        // Global resume drives K on the enabled port
        global_resume = 1'b1;
        step(5);
        cmp({1'b0, line_oe, dp_out, dm_out}, {2'b01, ~j_pair(low_spd)});
        global_resume = 1'b0;
        step(120);
        // Disconnect on the enabled port
        attach = 1'b0;
        step(8);
        chk(16'h000F, 16'h000A);
        cmp({3'b000, port_enabled}, 4'h0);
        summarize();
    end
endmodule : urp_port_tb
`default_nettype wire
